// *** lcs_top.sv ***
`timescale 1ns/1ns
`include "lcs_cfg.svh"

// Operation
// R1: Suppress motion after light off when enabled
// R2: Mode field picks on/off, PWM, pulse
// R3: Active period code sets sampling while loaded
// R4: Normal period code sets idle sampling rate
// R5: Host keeps both period codes consistent
// R6: Light and pulse last duration times 8ms
// R7: Trigger flag holds value times 4.2s
// R8: PWM duty equals duty byte over 255
// R9: Suppression lasts nibble times 260ms
// R10: Polarity bit selects active-high event output
// R11: New motion restarts running hold timers
module lcs_top #(
    parameter int unsigned BASE_TICK_CYC = `LCS_BASE_TICK_NS / `LCS_CLK_PERIOD_NS,
    parameter int unsigned MS_CYC        = `LCS_MS_NS / `LCS_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic CORE_CLK,
    input  wire logic RESETN,
    // Serial register bus, open drain data
    input  wire logic SCL_IN,
    input  wire logic SDA_IN,
    output logic      SDA_OUT,
    output logic      SDA_OE,
    // Motion sensor
    input  wire logic MOTION_IN,
    output logic      SAMPLE_TICK,
    // Outputs
    output logic      EVENT_OUT,
    output logic      TRIGGER_FLAG
);
    logic [1:0] scl_s_r, sda_s_r, mot_s_r;
    logic [7:0] out_fmt_r, light_cfg_r, act_per_r, norm_per_r;
    logic [7:0] bus_to_r, light_dur_r, hold_r, duty_r, mtim_r;
    logic [31:0] base_cnt_r, ms_cnt_r;
    logic [6:0]  samp_cnt_r;
    logic [8:0]  light_cnt_r;
    logic [18:0] hold_cnt_r;
    logic [10:0] block_cnt_r;
    logic [7:0]  pwm_cnt_r;
    logic        light_on_d_r;
    logic        sda_oe_i;
    lcs_pkg::lcs_wr_t wr;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    // Two-stage synchronisers; bus lines reset high so no false edge follows reset
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            mot_s_r <= 2'h0;
        end else begin
            scl_s_r <= {scl_s_r[0], SCL_IN};
            sda_s_r <= {sda_s_r[0], SDA_IN};
            mot_s_r <= {mot_s_r[0], MOTION_IN};
        end
    end

    lcs_i2c_slave u_bus (
        .clk     (CORE_CLK),
        .rst_n   (RESETN),
        .scl     (scl_s_r[1]),
        .sda     (sda_s_r[1]),
        .sda_oe  (sda_oe_i),
        .wr      (wr),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // Register write decode
    wire we_fmt  = wr.en & (wr.addr == `LCS_OFS_OUT_FORMAT);
    wire we_cfg  = wr.en & (wr.addr == `LCS_OFS_LIGHT_CFG);
    wire we_act  = wr.en & (wr.addr == `LCS_OFS_ACT_PERIOD);
    wire we_norm = wr.en & (wr.addr == `LCS_OFS_NORM_PERIOD);
    wire we_to   = wr.en & (wr.addr == `LCS_OFS_BUS_TIMEOUT);
    wire we_dur  = wr.en & (wr.addr == `LCS_OFS_LIGHT_DUR);
    wire we_hold = wr.en & (wr.addr == `LCS_OFS_TRIG_HOLD);
    wire we_duty = wr.en & (wr.addr == `LCS_OFS_PWM_DUTY);
    wire we_mtim = wr.en & (wr.addr == `LCS_OFS_MOTION_TIMING);

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            out_fmt_r   <= `LCS_RST_OUT_FORMAT;
            light_cfg_r <= `LCS_RST_LIGHT_CFG;
            act_per_r   <= `LCS_RST_ACT_PERIOD;
            norm_per_r  <= `LCS_RST_NORM_PERIOD;
            bus_to_r    <= `LCS_RST_BUS_TIMEOUT;
            light_dur_r <= `LCS_RST_LIGHT_DUR;
            hold_r      <= `LCS_RST_TRIG_HOLD;
            duty_r      <= `LCS_RST_PWM_DUTY;
            mtim_r      <= `LCS_RST_MOTION_TIMING;
        end else begin
            if (we_fmt)  out_fmt_r   <= wr.data;
            if (we_cfg)  light_cfg_r <= wr.data;
            if (we_act)  act_per_r   <= wr.data;
            if (we_norm) norm_per_r  <= wr.data;
            if (we_to)   bus_to_r    <= wr.data;
            if (we_dur)  light_dur_r <= wr.data;
            if (we_hold) hold_r      <= wr.data;
            if (we_duty) duty_r      <= wr.data;
            if (we_mtim) mtim_r      <= wr.data;
        end
    end

    // Read mux; unmapped addresses read zero
    assign rd_data = (rd_addr == `LCS_OFS_OUT_FORMAT)    ? out_fmt_r   :
                     (rd_addr == `LCS_OFS_LIGHT_CFG)     ? light_cfg_r :
                     (rd_addr == `LCS_OFS_ACT_PERIOD)    ? act_per_r   :
                     (rd_addr == `LCS_OFS_NORM_PERIOD)   ? norm_per_r  :
                     (rd_addr == `LCS_OFS_BUS_TIMEOUT)   ? bus_to_r    :
                     (rd_addr == `LCS_OFS_LIGHT_DUR)     ? light_dur_r :
                     (rd_addr == `LCS_OFS_TRIG_HOLD)     ? hold_r      :
                     (rd_addr == `LCS_OFS_PWM_DUTY)      ? duty_r      :
                     (rd_addr == `LCS_OFS_MOTION_TIMING) ? mtim_r      : 8'h00;

    // Time bases
    wire base_tick = (base_cnt_r == BASE_TICK_CYC - 1);
    wire ms_tick   = (ms_cnt_r == MS_CYC - 1);
    wire light_on  = (light_cnt_r != 9'h000);
    wire blocked   = (block_cnt_r != 11'h000);

    // R3 active code used while the load is on
    wire [7:0] act_code = act_per_r;
    // R4 normal code used otherwise
    wire [7:0] norm_code = norm_per_r;
    wire [6:0] act_ms  = (act_code == `LCS_ACT_100HZ) ? 7'(`LCS_PERIOD_100HZ_MS) :
                         (act_code == `LCS_ACT_50HZ)  ? 7'(`LCS_PERIOD_50HZ_MS)  :
                         (act_code == `LCS_ACT_20HZ)  ? 7'(`LCS_PERIOD_20HZ_MS)  :
                                                        7'(`LCS_PERIOD_10HZ_MS);
    wire [6:0] norm_ms = (norm_code == `LCS_NORM_100HZ) ? 7'(`LCS_PERIOD_100HZ_MS) :
                         (norm_code == `LCS_NORM_50HZ)  ? 7'(`LCS_PERIOD_50HZ_MS)  :
                         (norm_code == `LCS_NORM_20HZ)  ? 7'(`LCS_PERIOD_20HZ_MS)  :
                                                          7'(`LCS_PERIOD_10HZ_MS);
    wire [6:0] period_ms = light_on ? act_ms : norm_ms;
    wire samp_now = ms_tick & (samp_cnt_r >= period_ms - 7'h01);

    // R1 motion accepted only outside the suppression window
    wire motion_evt = samp_now & mot_s_r[1] & ~blocked;

    // R7 a zero hold value behaves as one unit
    wire [7:0]  hold_eff  = (hold_r == 8'h00) ? 8'h01 : hold_r;
    // R7 hold length in base ticks
    wire [18:0] hold_load = 19'(hold_eff) * 19'(`LCS_HOLD_UNIT_TICKS);
    // R6 light length in base ticks
    wire [8:0]  light_load = 9'(light_dur_r) * 9'(`LCS_LIGHT_UNIT_TICKS);
    // R9 suppression length in base ticks
    wire [10:0] block_load = 11'(mtim_r[7:4]) * 11'(`LCS_BLOCK_UNIT_TICKS);
    wire light_off_edge = light_on_d_r & ~light_on;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            base_cnt_r <= 32'h0;
            ms_cnt_r   <= 32'h0;
            samp_cnt_r <= 7'h00;
            SAMPLE_TICK <= 1'b0;
        end else begin
            base_cnt_r  <= base_tick ? 32'h0 : base_cnt_r + 32'h1;
            ms_cnt_r    <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
            SAMPLE_TICK <= samp_now;
            if (samp_now) begin
                samp_cnt_r <= 7'h00;
            end else if (ms_tick) begin
                samp_cnt_r <= samp_cnt_r + 7'h01;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            light_cnt_r  <= 9'h000;
            hold_cnt_r   <= 19'h00000;
            block_cnt_r  <= 11'h000;
            light_on_d_r <= 1'b0;
        end else begin
            light_on_d_r <= light_on;
            // R11 motion reloads running timers
            if (motion_evt) begin
                light_cnt_r <= light_load;
                hold_cnt_r  <= hold_load;
            end else if (base_tick) begin
                if (light_on) light_cnt_r <= light_cnt_r - 9'h001;
                if (hold_cnt_r != 19'h00000) hold_cnt_r <= hold_cnt_r - 19'h00001;
            end
            // R1 suppression armed when light goes off
            if (light_off_edge && light_cfg_r[`LCS_BIT_SUPPRESS]) begin
                block_cnt_r <= block_load;
            end else if (base_tick && blocked) begin
                block_cnt_r <= block_cnt_r - 11'h001;
            end
        end
    end

    // R8 PWM counter runs 0..254, so high time is duty/255
    wire pwm_level = (pwm_cnt_r < duty_r);
    wire trig_on   = (hold_cnt_r != 19'h00000);
    lcs_pkg::lcs_mode_t mode;
    assign mode = lcs_pkg::lcs_mode_t'(light_cfg_r[`LCS_MODE_HI:`LCS_MODE_LO]);

    // R2 drive style by mode; varied PWM shares the fixed PWM shape
    logic drive;
    always_comb begin
        case (mode)
            lcs_pkg::LCS_MODE_ONOFF:  drive = trig_on;
            lcs_pkg::LCS_MODE_VARPWM: drive = trig_on & pwm_level;
            lcs_pkg::LCS_MODE_FIXPWM: drive = trig_on & pwm_level;
            lcs_pkg::LCS_MODE_PULSE:  drive = light_on;
            default:                  drive = 1'b0;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pwm_cnt_r    <= 8'h00;
            EVENT_OUT    <= 1'b0;
            TRIGGER_FLAG <= 1'b0;
            SDA_OUT      <= 1'b0;
            SDA_OE       <= 1'b0;
        end else begin
            pwm_cnt_r    <= (pwm_cnt_r == `LCS_PWM_TOP) ? 8'h00 : pwm_cnt_r + 8'h01;
            // R10 polarity applied last
            EVENT_OUT    <= drive ^ ~out_fmt_r[`LCS_BIT_ACTIVE_HIGH];
            // R7 flag stands for the whole hold time
            TRIGGER_FLAG <= trig_on;
            SDA_OUT      <= 1'b0;
            SDA_OE       <= sda_oe_i;
        end
    end
endmodule

// *** lcs_cfg.svh ***
`ifndef LCS_CFG_SVH
`define LCS_CFG_SVH

// Register offsets
`define LCS_OFS_OUT_FORMAT      8'hD2
`define LCS_OFS_LIGHT_CFG       8'hD3
`define LCS_OFS_ACT_PERIOD      8'hD4
`define LCS_OFS_NORM_PERIOD     8'hD5
`define LCS_OFS_BUS_TIMEOUT     8'hD7
`define LCS_OFS_LIGHT_DUR       8'hD8
`define LCS_OFS_TRIG_HOLD       8'hD9
`define LCS_OFS_PWM_DUTY        8'hF8
`define LCS_OFS_MOTION_TIMING   8'h95

// Field positions
`define LCS_BIT_SUPPRESS        7
`define LCS_BIT_ACTIVE_HIGH     7
`define LCS_MODE_HI             1
`define LCS_MODE_LO             0

// Reset values
`define LCS_RST_OUT_FORMAT      8'h80
`define LCS_RST_LIGHT_CFG       8'h00
`define LCS_RST_ACT_PERIOD      8'h06
`define LCS_RST_NORM_PERIOD     8'h1E
`define LCS_RST_BUS_TIMEOUT     8'h00
`define LCS_RST_LIGHT_DUR       8'h7D
`define LCS_RST_TRIG_HOLD       8'h01
`define LCS_RST_PWM_DUTY        8'h80
`define LCS_RST_MOTION_TIMING   8'h00

// Sample period codes, active then normal, for 10/20/50/100 Hz
`define LCS_ACT_10HZ            8'h06
`define LCS_ACT_20HZ            8'h02
`define LCS_ACT_50HZ            8'h01
`define LCS_ACT_100HZ           8'h00
`define LCS_NORM_10HZ           8'h1E
`define LCS_NORM_20HZ           8'h0B
`define LCS_NORM_50HZ           8'h06
`define LCS_NORM_100HZ          8'h04

// Timing: clock period, base tick, time units expressed in base ticks
`define LCS_CLK_PERIOD_NS       10
`define LCS_BASE_TICK_NS        4000000
`define LCS_MS_NS               1000000
`define LCS_LIGHT_UNIT_MS       8
`define LCS_BLOCK_UNIT_MS       260
`define LCS_HOLD_UNIT_MS        4200
`define LCS_BASE_TICK_MS        4
`define LCS_LIGHT_UNIT_TICKS    (`LCS_LIGHT_UNIT_MS / `LCS_BASE_TICK_MS)
`define LCS_BLOCK_UNIT_TICKS    (`LCS_BLOCK_UNIT_MS / `LCS_BASE_TICK_MS)
`define LCS_HOLD_UNIT_TICKS     (`LCS_HOLD_UNIT_MS / `LCS_BASE_TICK_MS)
`define LCS_PERIOD_10HZ_MS      100
`define LCS_PERIOD_20HZ_MS      50
`define LCS_PERIOD_50HZ_MS      20
`define LCS_PERIOD_100HZ_MS     10
`define LCS_PWM_TOP             8'hFE

// Bus address of the device, arbitrary value
`define LCS_BUS_ADDR            7'h44

`endif

// *** lcs_pkg.sv ***
package lcs_pkg;

    typedef enum logic [2:0] {
        LCS_ST_IDLE  = 3'b000,
        LCS_ST_ADDR  = 3'b001,
        LCS_ST_PTR   = 3'b010,
        LCS_ST_WDATA = 3'b011,
        LCS_ST_RDATA = 3'b100
    } lcs_bus_state_t;

    typedef enum logic [1:0] {
        LCS_MODE_ONOFF  = 2'b00,
        LCS_MODE_VARPWM = 2'b01,
        LCS_MODE_FIXPWM = 2'b10,
        LCS_MODE_PULSE  = 2'b11
    } lcs_mode_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } lcs_wr_t;

endpackage

// *** lcs_i2c_slave.sv ***
`timescale 1ns/1ns
`include "lcs_cfg.svh"

module lcs_i2c_slave (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Synchronised bus lines
    input  wire logic            scl,
    input  wire logic            sda,
    output logic                 sda_oe,
    // Register access
    output lcs_pkg::lcs_wr_t     wr,
    output logic [7:0]           rd_addr,
    input  wire logic [7:0]      rd_data
);
    lcs_pkg::lcs_bus_state_t st_r;
    logic [3:0] bcnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic       scl_d_r;
    logic       sda_d_r;

    wire scl_rise  = scl & ~scl_d_r;
    wire scl_fall  = ~scl & scl_d_r;
    wire start_det = scl & scl_d_r & sda_d_r & ~sda;
    wire stop_det  = scl & scl_d_r & ~sda_d_r & sda;
    wire byte_done = scl_fall & (bcnt_r == 4'h7);
    wire ack_done  = scl_fall & (bcnt_r == 4'h8);
    wire addr_hit  = (sh_r[7:1] == `LCS_BUS_ADDR);

    assign rd_addr = ptr_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl;
            sda_d_r <= sda;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= lcs_pkg::LCS_ST_IDLE;
            bcnt_r <= 4'h0;
            sh_r   <= 8'h00;
            tx_r   <= 8'h00;
            ptr_r  <= 8'h00;
            sda_oe <= 1'b0;
            wr     <= '0;
        end else begin
            wr.en <= 1'b0;
            if (start_det) begin
                st_r   <= lcs_pkg::LCS_ST_ADDR;
                // The clock fall that closes a start carries no bit
                bcnt_r <= 4'hF;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                st_r   <= lcs_pkg::LCS_ST_IDLE;
                sda_oe <= 1'b0;
            end else if (st_r != lcs_pkg::LCS_ST_IDLE) begin
                if (scl_rise && bcnt_r < 4'h8) begin
                    sh_r <= {sh_r[6:0], sda};
                end
                // Master NACK ends a read burst
                if (scl_rise && bcnt_r == 4'h8 && st_r == lcs_pkg::LCS_ST_RDATA && sda) begin
                    st_r <= lcs_pkg::LCS_ST_IDLE;
                end
                if (byte_done) begin
                    bcnt_r <= 4'h8;
                    sda_oe <= 1'b1;
                    case (st_r)
                        lcs_pkg::LCS_ST_ADDR: begin
                            if (!addr_hit) begin
                                st_r   <= lcs_pkg::LCS_ST_IDLE;
                                sda_oe <= 1'b0;
                            end
                        end
                        lcs_pkg::LCS_ST_PTR: begin
                            ptr_r <= sh_r;
                        end
                        lcs_pkg::LCS_ST_WDATA: begin
                            wr    <= '{en: 1'b1, addr: ptr_r, data: sh_r};
                            ptr_r <= ptr_r + 8'h01;
                        end
                        default: begin
                            sda_oe <= 1'b0;
                        end
                    endcase
                end else if (ack_done) begin
                    bcnt_r <= 4'h0;
                    sda_oe <= 1'b0;
                    case (st_r)
                        lcs_pkg::LCS_ST_ADDR: begin
                            if (sh_r[0]) begin
                                st_r   <= lcs_pkg::LCS_ST_RDATA;
                                tx_r   <= rd_data;
                                sda_oe <= ~rd_data[7];
                                ptr_r  <= ptr_r + 8'h01;
                            end else begin
                                st_r <= lcs_pkg::LCS_ST_PTR;
                            end
                        end
                        lcs_pkg::LCS_ST_PTR: begin
                            st_r <= lcs_pkg::LCS_ST_WDATA;
                        end
                        lcs_pkg::LCS_ST_RDATA: begin
                            tx_r   <= rd_data;
                            sda_oe <= ~rd_data[7];
                            ptr_r  <= ptr_r + 8'h01;
                        end
                        default: begin
                            st_r <= st_r;
                        end
                    endcase
                end else if (scl_fall && bcnt_r == 4'hF) begin
                    bcnt_r <= 4'h0;
                end else if (scl_fall && bcnt_r < 4'h7) begin
                    bcnt_r <= bcnt_r + 4'h1;
                    if (st_r == lcs_pkg::LCS_ST_RDATA) begin
                        tx_r   <= {tx_r[6:0], 1'b0};
                        sda_oe <= ~tx_r[6];
                    end
                end
            end
        end
    end
endmodule

// *** lcs_top_chk.sv ***
`timescale 1ns/1ns
module lcs_top_chk #(
    parameter int unsigned BASE_TICK_CYC = 10,
    parameter int unsigned MS_CYC        = 4
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // Register bus pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    // Motion and outputs
    input wire logic MOTION_IN,
    input wire logic SAMPLE_TICK,
    input wire logic EVENT_OUT,
    input wire logic TRIGGER_FLAG
);
    // One base tick of slack: the hold may start just before a tick
    localparam int unsigned HOLD_MIN = 1049 * BASE_TICK_CYC;
    logic [31:0] gap_r;
    logic [31:0] high_r;
    logic [3:0]  quiet_r;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            gap_r <= '0;
            high_r <= '0;
            quiet_r <= 4'hF;
        end else begin
            gap_r <= SAMPLE_TICK ? 32'h1 : gap_r + 32'h1;
            high_r <= TRIGGER_FLAG ? high_r + 32'h1 : 32'h0;
            quiet_r <= MOTION_IN ? 4'h0 : (quiet_r == 4'hF ? quiet_r : quiet_r + 4'h1);
        end
    end

    AST_TICK_ONE: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
        else $error("sample tick wider than one cycle");
    AST_TICK_MIN: assert property (SAMPLE_TICK && gap_r != 0 |-> gap_r >= 10 * MS_CYC)
        else $error("sample period below 10 ms");
    AST_TICK_MAX: assert property (gap_r <= 100 * MS_CYC)
        else $error("sample period above 100 ms");
    AST_FLAG_AFTER_TICK: assert property ($rose(TRIGGER_FLAG) |-> $past(SAMPLE_TICK))
        else $error("trigger flag rose off a sample instant");
    AST_FLAG_MOTION: assert property ($rose(TRIGGER_FLAG) |-> quiet_r < 4'h8)
        else $error("trigger flag rose without motion");
    AST_FLAG_STAYS: assert property ($rose(TRIGGER_FLAG) |=> TRIGGER_FLAG [*8])
        else $error("trigger flag dropped early");
    AST_FLAG_LENGTH: assert property ($fell(TRIGGER_FLAG) |-> high_r >= HOLD_MIN)
        else $error("trigger hold too short");
    AST_RESET_QUIET: assert property ($rose(RESETN) |-> !EVENT_OUT && !TRIGGER_FLAG)
        else $error("outputs active after reset");
    AST_SDA_LOW: assert property (SDA_OUT == 1'b0)
        else $error("data pin output not low");
endmodule

bind lcs_top lcs_top_chk #(.BASE_TICK_CYC(BASE_TICK_CYC), .MS_CYC(MS_CYC)) i_chk (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .MOTION_IN(MOTION_IN),
    .SAMPLE_TICK(SAMPLE_TICK), .EVENT_OUT(EVENT_OUT), .TRIGGER_FLAG(TRIGGER_FLAG)
);

// *** lcs_host_model.sv ***
`timescale 1ns/1ns
`include "lcs_cfg.svh"
module lcs_host_model #(
    parameter int HALF = 10
) (
    // Clock
    input  wire logic clk,
    // Bus lines
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic pause;
        repeat (HALF) @(negedge clk);
    endtask
    task automatic start;
        sda_drv = 1'b1;
        pause();
        scl = 1'b1;
        pause();
        sda_drv = 1'b0;
        pause();
        scl = 1'b0;
    endtask
    task automatic stop;
        sda_drv = 1'b0;
        pause();
        scl = 1'b1;
        pause();
        sda_drv = 1'b1;
        pause();
    endtask
    // Data held past the clock fall so it never looks like a start or stop
    task automatic xfer(input logic [8:0] v, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_drv = v[i];
            pause();
            scl = 1'b1;
            pause();
            r[i] = sda_wire;
            scl = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        start();
        xfer({`LCS_BUS_ADDR, 2'b01}, r);
        xfer({a, 1'b1}, r);
        xfer({d, 1'b1}, r);
        stop();
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        logic [8:0] r;
        start();
        xfer({`LCS_BUS_ADDR, 2'b01}, r);
        xfer({a, 1'b1}, r);
        start();
        xfer({`LCS_BUS_ADDR, 2'b11}, r);
        // Last bit left high: not-acknowledge ends the read
        xfer(9'h1FF, r);
        d = r[8:1];
        stop();
    endtask
endmodule

// *** lcs_top_tb.sv ***
`timescale 1ns/1ns
module lcs_top_tb;
    localparam int BT = 10;
    localparam int MS = 4;
    logic CORE_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic MOTION_IN = 1'b0;
    logic scl;
    logic sda_drv;
    logic SDA_OUT;
    logic SDA_OE;
    logic SAMPLE_TICK;
    logic EVENT_OUT;
    logic TRIGGER_FLAG;
    wire  sda_wire = sda_drv & ~SDA_OE;
    int   n_mismatch = 0;
    int   num_checks = 0;
    int   n;
    logic [7:0] d;

    always #5 CORE_CLK = ~CORE_CLK;

    lcs_top #(.BASE_TICK_CYC(BT), .MS_CYC(MS)) i_dut (
        .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SCL_IN(scl), .SDA_IN(sda_wire),
        .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .MOTION_IN(MOTION_IN),
        .SAMPLE_TICK(SAMPLE_TICK), .EVENT_OUT(EVENT_OUT), .TRIGGER_FLAG(TRIGGER_FLAG)
    );
    lcs_host_model i_host (.clk(CORE_CLK), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask
    function automatic logic sig(input int k);
        return k == 0 ? SAMPLE_TICK : (k == 1 ? TRIGGER_FLAG : EVENT_OUT);
    endfunction
    task automatic wait_sig(input int k, input logic v, input int lim);
        n = 0;
        while (sig(k) !== v) begin
            @(negedge CORE_CLK);
            n++;
            if (n > lim) begin
                check(0, 1, "timeout");
                test_done();
            end
        end
    endtask
    task automatic kick(input int k, input int lim);
        MOTION_IN = 1'b1;
        wait_sig(k, 1'b1, lim);
        MOTION_IN = 1'b0;
    endtask
    task automatic gap;
        wait_sig(0, 1'b1, 2000);
        @(negedge CORE_CLK);
        wait_sig(0, 1'b1, 2000);
        n = n + 1;
    endtask
    task automatic do_reset;
        RESETN = 1'b0;
        repeat (6) @(negedge CORE_CLK);
        RESETN = 1'b1;
        repeat (4) @(negedge CORE_CLK);
    endtask

    task automatic test_regs;
        logic [7:0] ofs [9] = '{8'h95, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD7, 8'hD8, 8'hD9, 8'hF8};
        logic [7:0] rst [9] = '{8'h00, 8'h80, 8'h00, 8'h06, 8'h1E, 8'h00, 8'h7D, 8'h01, 8'h80};
        for (int i = 0; i < 9; i++) begin
            i_host.rd_reg(ofs[i], d);
            check(d, rst[i], "reset value");
            i_host.wr_reg(ofs[i], 8'hA5 ^ 8'(i));
            i_host.rd_reg(ofs[i], d);
            check(d, 8'hA5 ^ 8'(i), "read back");
        end
        i_host.wr_reg(8'hD6, 8'h5A);
        i_host.rd_reg(8'hD6, d);
        check(d, 8'h00, "unmapped");
        $display("test_regs done");
    endtask
    task automatic test_hold;
        do_reset();
        kick(1, 500);
        check(EVENT_OUT, 1'b1, "on/off event");
        wait_sig(1, 1'b0, 11000);
        check(n >= 1049 * BT && n <= 1050 * BT + BT, 1'b1, "hold time");
        kick(1, 500);
        repeat (3000) @(negedge CORE_CLK);
        // Motion spans a whole 10 Hz sample period
        MOTION_IN = 1'b1;
        repeat (450) @(negedge CORE_CLK);
        MOTION_IN = 1'b0;
        wait_sig(1, 1'b0, 12000);
        check(n >= 1049 * BT - 450, 1'b1, "retrigger");
        $display("test_hold done");
    endtask
    task automatic test_pol;
        do_reset();
        i_host.wr_reg(8'hD2, 8'h00);
        repeat (4) @(negedge CORE_CLK);
        check(EVENT_OUT, 1'b1, "active low idle");
        kick(1, 500);
        check(EVENT_OUT, 1'b0, "active low event");
        $display("test_pol done");
    endtask
    task automatic test_rates;
        logic [7:0] act [4] = '{8'd6, 8'd2, 8'd1, 8'd0};
        logic [7:0] nrm [4] = '{8'd30, 8'd11, 8'd6, 8'd4};
        int per [4] = '{100, 50, 20, 10};
        do_reset();
        for (int i = 0; i < 4; i++) begin
            i_host.wr_reg(8'hD4, act[i]);
            i_host.wr_reg(8'hD5, nrm[i]);
            gap();
            check(n, per[i] * MS, "normal period");
        end
        // Codes disagree on purpose so that the active rate shows
        i_host.wr_reg(8'hD5, 8'd30);
        i_host.wr_reg(8'hD4, 8'd0);
        i_host.wr_reg(8'hD8, 8'h40);
        kick(1, 500);
        gap();
        check(n, 10 * MS, "active period");
        repeat (1500) @(negedge CORE_CLK);
        gap();
        check(n, 100 * MS, "normal again");
        $display("test_rates done");
    endtask
    task automatic test_pwm;
        logic [1:0] md [3] = '{2'b01, 2'b10, 2'b10};
        logic [7:0] dt [3] = '{8'h40, 8'h01, 8'hFF};
        do_reset();
        for (int i = 0; i < 3; i++) begin
            i_host.wr_reg(8'hD3, {6'h00, md[i]});
            i_host.wr_reg(8'hF8, dt[i]);
            if (i == 0) kick(1, 500);
            n = 0;
            repeat (255) begin
                @(negedge CORE_CLK);
                n += int'(EVENT_OUT === 1'b1);
            end
            check(n, dt[i], "duty");
        end
        $display("test_pwm done");
    endtask
    task automatic test_pulse;
        do_reset();
        i_host.wr_reg(8'hD4, 8'd0);
        i_host.wr_reg(8'hD5, 8'd4);
        i_host.wr_reg(8'hD8, 8'h02);
        i_host.wr_reg(8'hD3, 8'h03);
        kick(2, 500);
        wait_sig(2, 1'b0, 200);
        check(n >= 3 * BT && n <= 5 * BT, 1'b1, "pulse length");
        kick(2, 500);
        check(n <= 90, 1'b1, "relight unsuppressed");
        wait_sig(2, 1'b0, 200);
        i_host.wr_reg(8'h95, 8'h10);
        i_host.wr_reg(8'hD3, 8'h83);
        kick(2, 500);
        wait_sig(2, 1'b0, 200);
        kick(2, 1000);
        check(n >= 64 * BT && n <= 66 * BT + 80, 1'b1, "suppressed window");
        $display("test_pulse done");
    endtask

    initial begin
        do_reset();
        test_regs();
        test_hold();
        test_pol();
        test_rates();
        test_pwm();
        test_pulse();
        test_done();
    end
endmodule
